/* common/csa_params.svh */
// Constants for the channel start and hop alignment controller
`ifndef CSA_PARAMS_SVH
`define CSA_PARAMS_SVH
`define CSA_ADDR_SOFT_CFG 8'h03
`define CSA_ADDR_PIN_CFG 8'h04
`define CSA_ADDR_CHAN_EN 8'h05
`define CSA_ADDR_SLEEP 8'h06
`define CSA_ADDR_START_LO 8'h08
`define CSA_ADDR_START_HI 8'h09
`define CSA_ADDR_HOP_LO 8'h0a
`define CSA_ADDR_HOP_HI 8'h0b
`define CSA_ADDR_PINSEL 8'h0c
`define CSA_ADDR_STATUS 8'h0d
`define CSA_BIT_START_EN 7
`define CSA_BIT_HOP_EN 6
`define CSA_BIT_EDGE 5
`define CSA_PIN_EN_LSB 0
`define CSA_RESET_BYTE 8'h00
`define CSA_RESET_HOLD 16'h0001
`define CSA_COUNT_FIRE 16'h0001
`endif

/* common/csa_pkg.sv */
// Types for the alignment controller
package csa_pkg;
  typedef logic [7:0] csa_byte_t;
  typedef logic [15:0] csa_count_t;
  typedef enum logic {CSA_WRITE, CSA_READ} csa_op_e;
endpackage

/* common/csa_if.sv */
// Interface joining the host end and the device end
`timescale 1ns/1ps
interface csa_if;
  logic regReq;
  csa_pkg::csa_op_e regOp;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic regAck;
  logic [3:0] alignPin;
  modport device (input regReq, input regOp, input regAddr, input regWdata, input alignPin,
    output regRdata, output regAck);
  modport host (output regReq, output regOp, output regAddr, output regWdata, output alignPin,
    input regRdata, input regAck);
endinterface

/* hw/csa_holdoff.sv */
// Hold-off down counter, one instance each for start and hop events
`timescale 1ns/1ps
`include "csa_params.svh"
module csa_holdoff
#(
  parameter int WIDTH = 16
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic arm,
  input wire logic [WIDTH-1:0] loadValue,
  output logic fire,
  output logic busy
);
  logic [WIDTH-1:0] count_ff;
  logic busy_ff;

  if (WIDTH < 2)
  begin : g_widthCheck
    $error("WIDTH too small");
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      count_ff <= WIDTH'(`CSA_RESET_HOLD);
    end
    else if (arm)
    begin
      count_ff <= loadValue;
    end
    else if (busy_ff && count_ff != WIDTH'(`CSA_COUNT_FIRE))
    begin
      count_ff <= count_ff - WIDTH'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      busy_ff <= 1'b0;
    end
    else if (arm)
    begin
      busy_ff <= 1'b1;
    end
    else if (fire)
    begin
      busy_ff <= 1'b0;
    end
  end

  assign fire = busy_ff && !arm && count_ff == WIDTH'(`CSA_COUNT_FIRE);
  assign busy = busy_ff;
endmodule

/* hw/csa_device.sv */
// Device end: alignment registers, pin detection and event control
// Notes on behaviour
// - Start event wakes channels; hop loads tuning
// - Software writes can trigger either event
// - Four pins; each channel watches one
// - Register 0x04 picks edge or level detection
// - Reset puts every channel to sleep
// - Writing zero to sleep register sleeps channels; the write is ignored if start fires that cycle
// - Host enables channels before arming start
// - Host loads start hold-off 1 to 65535
// - Software start arms countdown, fires at one
// - Serial hosts write software config twice
// - Host selects each channel's pin first
// - Pin start enable arms countdown, fires at one
// - Host clears software config before hop
// - Software hop arms countdown, loads tuning
// - Host loads hop hold-off 1 to 65535
// - Pin hop enable arms countdown, loads tuning
`timescale 1ns/1ps
`include "csa_params.svh"
module csa_device
#(
  parameter int CHANNELS = 4
)
(
  input wire logic clk,
  input wire logic rst_b,
  csa_if.device link,
  output logic [CHANNELS-1:0] chanAwake,
  output logic [CHANNELS-1:0] startPulse,
  output logic [CHANNELS-1:0] hopLoad
);
  import csa_pkg::*;

  // ************
  // Registers
  // ************
  csa_byte_t softCfg_ff;
  csa_byte_t pinCfg_ff;
  logic [CHANNELS-1:0] chanEn_ff;
  logic [CHANNELS-1:0] awake_ff;
  csa_count_t startHold_ff;
  csa_count_t hopHold_ff;
  csa_byte_t pinSel_ff;
  csa_byte_t rdata_ff;
  logic ack_ff;
  logic [3:0] pinPrev_ff;
  logic [CHANNELS-1:0] startTgt_ff;
  logic [CHANNELS-1:0] hopTgt_ff;
  logic [CHANNELS-1:0] startPulse_ff;
  logic [CHANNELS-1:0] hopLoad_ff;
  logic wr;
  logic [3:0] pinEvent;
  logic [CHANNELS-1:0] chanPinHit;
  logic startBusy;
  logic hopBusy;
  logic armStart;
  logic armHop;
  logic startFire;
  logic hopFire;
  logic [CHANNELS-1:0] nxt_startTgt;
  logic [CHANNELS-1:0] nxt_hopTgt;

  if (CHANNELS < 1 || CHANNELS > 4)
  begin : g_chanCheck
    $error("CHANNELS must be 1 to 4");
  end

  function automatic logic [1:0] pinOf(input csa_byte_t sel, input int ch);
    pinOf = sel[2*ch +: 2];
  endfunction

  assign wr = link.regReq && link.regOp == CSA_WRITE;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      softCfg_ff <= `CSA_RESET_BYTE;
      pinCfg_ff <= `CSA_RESET_BYTE;
      chanEn_ff <= '0;
      startHold_ff <= '0;
      hopHold_ff <= '0;
      pinSel_ff <= `CSA_RESET_BYTE;
    end
    else if (wr)
    begin
      unique case (link.regAddr)
        `CSA_ADDR_SOFT_CFG: softCfg_ff <= link.regWdata;
        `CSA_ADDR_PIN_CFG: pinCfg_ff <= link.regWdata;
        `CSA_ADDR_CHAN_EN: chanEn_ff <= link.regWdata[CHANNELS-1:0];
        `CSA_ADDR_START_LO: startHold_ff[7:0] <= link.regWdata;
        `CSA_ADDR_START_HI: startHold_ff[15:8] <= link.regWdata;
        `CSA_ADDR_HOP_LO: hopHold_ff[7:0] <= link.regWdata;
        `CSA_ADDR_HOP_HI: hopHold_ff[15:8] <= link.regWdata;
        `CSA_ADDR_PINSEL: pinSel_ff <= link.regWdata;
        default: ;
      endcase
    end
  end

  // ************
  // Pin detection
  // ************
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pinPrev_ff <= 4'h0;
    end
    else
    begin
      pinPrev_ff <= link.alignPin;
    end
  end

  assign pinEvent = pinCfg_ff[`CSA_BIT_EDGE] ? (link.alignPin & ~pinPrev_ff) : link.alignPin;

  always_comb
  begin
    for (int ch = 0; ch < CHANNELS; ch++)
    begin
      chanPinHit[ch] = pinEvent[pinOf(pinSel_ff, ch)] && pinCfg_ff[`CSA_PIN_EN_LSB + pinOf(pinSel_ff, ch)];
    end
  end

  // ************
  // Arming
  // ************
  always_comb
  begin
    armStart = 1'b0;
    armHop = 1'b0;
    nxt_startTgt = startTgt_ff;
    nxt_hopTgt = hopTgt_ff;
    if (wr && link.regAddr == `CSA_ADDR_SOFT_CFG && link.regWdata[`CSA_BIT_START_EN]
        && |link.regWdata[CHANNELS-1:0])
    begin
      armStart = 1'b1;
      nxt_startTgt = link.regWdata[CHANNELS-1:0];
    end
    else if (pinCfg_ff[`CSA_BIT_START_EN] && |chanPinHit)
    begin
      armStart = 1'b1;
      nxt_startTgt = chanPinHit;
    end
    if (wr && link.regAddr == `CSA_ADDR_SOFT_CFG && link.regWdata[`CSA_BIT_HOP_EN]
        && |link.regWdata[CHANNELS-1:0])
    begin
      armHop = 1'b1;
      nxt_hopTgt = link.regWdata[CHANNELS-1:0];
    end
    else if (pinCfg_ff[`CSA_BIT_HOP_EN] && |chanPinHit)
    begin
      armHop = 1'b1;
      nxt_hopTgt = chanPinHit;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      startTgt_ff <= '0;
      hopTgt_ff <= '0;
    end
    else
    begin
      startTgt_ff <= nxt_startTgt;
      hopTgt_ff <= nxt_hopTgt;
    end
  end

  csa_holdoff #(.WIDTH(16)) startCounter
  (
    .clk(clk),
    .rst_b(rst_b),
    .arm(armStart),
    .loadValue(startHold_ff),
    .fire(startFire),
    .busy(startBusy)
  );

  csa_holdoff #(.WIDTH(16)) hopCounter
  (
    .clk(clk),
    .rst_b(rst_b),
    .arm(armHop),
    .loadValue(hopHold_ff),
    .fire(hopFire),
    .busy(hopBusy)
  );

  // ************
  // Channel state
  // ************
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      awake_ff <= '0;
    end
    else if (startFire)
    begin
      awake_ff <= awake_ff | (startTgt_ff & chanEn_ff);
    end
    else if (wr && link.regAddr == `CSA_ADDR_SLEEP)
    begin
      awake_ff <= awake_ff & link.regWdata[CHANNELS-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      startPulse_ff <= '0;
      hopLoad_ff <= '0;
    end
    else
    begin
      startPulse_ff <= startFire ? (startTgt_ff & chanEn_ff) : '0;
      hopLoad_ff <= hopFire ? hopTgt_ff : '0;
    end
  end

  // ************
  // Read path
  // ************
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rdata_ff <= `CSA_RESET_BYTE;
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= link.regReq;
      if (link.regReq && link.regOp == CSA_READ)
      begin
        unique case (link.regAddr)
          `CSA_ADDR_SOFT_CFG: rdata_ff <= softCfg_ff;
          `CSA_ADDR_PIN_CFG: rdata_ff <= pinCfg_ff;
          `CSA_ADDR_CHAN_EN: rdata_ff <= 8'(chanEn_ff);
          `CSA_ADDR_SLEEP: rdata_ff <= 8'(awake_ff);
          `CSA_ADDR_START_LO: rdata_ff <= startHold_ff[7:0];
          `CSA_ADDR_START_HI: rdata_ff <= startHold_ff[15:8];
          `CSA_ADDR_HOP_LO: rdata_ff <= hopHold_ff[7:0];
          `CSA_ADDR_HOP_HI: rdata_ff <= hopHold_ff[15:8];
          `CSA_ADDR_PINSEL: rdata_ff <= pinSel_ff;
          `CSA_ADDR_STATUS: rdata_ff <= {6'h00, hopBusy, startBusy};
          default: rdata_ff <= `CSA_RESET_BYTE;
        endcase
      end
    end
  end

  assign link.regRdata = rdata_ff;
  assign link.regAck = ack_ff;
  assign chanAwake = awake_ff;
  assign startPulse = startPulse_ff;
  assign hopLoad = hopLoad_ff;
endmodule

/* hw/csa_host.sv */
// Host end: issues register writes and reads, drives alignment pins
`timescale 1ns/1ps
`include "csa_params.svh"
module csa_host
(
  input wire logic clk,
  input wire logic rst_b,
  csa_if.host link,
  input wire logic cmdValid,
  input wire logic cmdRead,
  input wire logic [7:0] cmdAddr,
  input wire logic [7:0] cmdData,
  output logic cmdReady,
  output logic [7:0] rspData,
  output logic rspValid,
  input wire logic [3:0] pinIn
);
  import csa_pkg::*;

  typedef enum logic {CSA_IDLE, CSA_WAIT} csa_state_e;
  csa_state_e state_ff;
  logic req_ff;
  csa_op_e op_ff;
  logic [7:0] addr_ff;
  logic [7:0] data_ff;
  logic [7:0] rsp_ff;
  logic rspValid_ff;
  logic [3:0] pin_ff;

  // Single outstanding access; are sequencing left to the user
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_ff <= CSA_IDLE;
      req_ff <= 1'b0;
      op_ff <= CSA_WRITE;
      addr_ff <= 8'h00;
      data_ff <= 8'h00;
    end
    else
    begin
      unique case (state_ff)
        CSA_IDLE:
        begin
          if (cmdValid)
          begin
            req_ff <= 1'b1;
            op_ff <= cmdRead ? CSA_READ : CSA_WRITE;
            addr_ff <= cmdAddr;
            data_ff <= cmdData;
            state_ff <= CSA_WAIT;
          end
        end
        CSA_WAIT:
        begin
          req_ff <= 1'b0;
          if (link.regAck)
          begin
            state_ff <= CSA_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rsp_ff <= 8'h00;
      rspValid_ff <= 1'b0;
      pin_ff <= 4'h0;
    end
    else
    begin
      pin_ff <= pinIn;
      rspValid_ff <= state_ff == CSA_WAIT && link.regAck && op_ff == CSA_READ;
      if (state_ff == CSA_WAIT && link.regAck)
      begin
        rsp_ff <= link.regRdata;
      end
    end
  end

  assign cmdReady = state_ff == CSA_IDLE;
  assign link.regReq = req_ff;
  assign link.regOp = op_ff;
  assign link.regAddr = addr_ff;
  assign link.regWdata = data_ff;
  assign link.alignPin = pin_ff;
  assign rspData = rsp_ff;
  assign rspValid = rspValid_ff;
endmodule

/* tb/csa_properties.sv */
// Concurrent checks on the register link
`timescale 1ns/1ps
`include "csa_params.svh"
module csa_properties
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic regReq,
  input wire csa_pkg::csa_op_e regOp,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regAck,
  input wire logic [3:0] alignPin
);
  import csa_pkg::*;
  logic wr;
  logic rdReq;
  logic [7:0] pinCfg_ff;
  logic [15:0] startHold_ff;
  logic [15:0] hopHold_ff;
  assign wr = regReq && regOp == CSA_WRITE;
  assign rdReq = regReq && regOp == CSA_READ;
  // ****************************************
  // Shadow registers
  // ****************************************
  always_ff @(posedge clk)
    if (!rst_b)
      pinCfg_ff <= 8'h00;
    else if (wr && regAddr == `CSA_ADDR_PIN_CFG)
      pinCfg_ff <= regWdata;
  always_ff @(posedge clk)
    if (!rst_b)
      startHold_ff <= '0;
    else if (wr && regAddr == `CSA_ADDR_START_LO)
      startHold_ff[7:0] <= regWdata;
    else if (wr && regAddr == `CSA_ADDR_START_HI)
      startHold_ff[15:8] <= regWdata;
  always_ff @(posedge clk)
    if (!rst_b)
      hopHold_ff <= '0;
    else if (wr && regAddr == `CSA_ADDR_HOP_LO)
      hopHold_ff[7:0] <= regWdata;
    else if (wr && regAddr == `CSA_ADDR_HOP_HI)
      hopHold_ff[15:8] <= regWdata;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  property p_ack_follows; regReq |=> regAck; endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("no ack after request");
  property p_ack_cause; regAck |-> $past(regReq); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_req_spacing; regReq |=> !regReq; endproperty
  a_req_spacing: assert property (p_req_spacing) else $error("requests too close");
  property p_pin_cfg_read; rdReq && regAddr == `CSA_ADDR_PIN_CFG |=> regRdata == pinCfg_ff; endproperty
  a_pin_cfg_read: assert property (p_pin_cfg_read) else $error("pin config readback wrong");
  property p_unmapped; rdReq && regAddr > `CSA_ADDR_STATUS |=> regRdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rdata_hold; !rdReq |=> $stable(regRdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_start_hold;
    wr && regAddr == `CSA_ADDR_SOFT_CFG && regWdata[`CSA_BIT_START_EN] |-> startHold_ff != 16'h0000;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start armed with zero hold");
  property p_hop_hold;
    wr && regAddr == `CSA_ADDR_SOFT_CFG && regWdata[`CSA_BIT_HOP_EN] |-> hopHold_ff != 16'h0000;
  endproperty
  a_hop_hold: assert property (p_hop_hold) else $error("hop armed with zero hold");
  c_soft: cover property (wr && regAddr == `CSA_ADDR_SOFT_CFG);
  c_pin_read: cover property (rdReq && regAddr == `CSA_ADDR_PIN_CFG);
  c_pin_high: cover property (alignPin != 4'h0);
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the host and device pair
`timescale 1ns/1ps
`include "csa_params.svh"
module tb_top;
  import csa_pkg::*;
  logic clk;
  logic rst_b;
  logic cmdValid;
  logic cmdRead;
  logic [7:0] cmdAddr;
  logic [7:0] cmdData;
  logic cmdReady;
  logic [7:0] rspData;
  logic rspValid;
  logic [3:0] pinIn;
  logic [3:0] chanAwake;
  logic [3:0] startPulse;
  logic [3:0] hopLoad;
  logic [7:0] rd;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int tTaken;
  int tEv;
  csa_if link();
  csa_host u_csa_host (.clk(clk), .rst_b(rst_b), .link(link.host), .cmdValid(cmdValid), .cmdRead(cmdRead),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady), .rspData(rspData), .rspValid(rspValid),
    .pinIn(pinIn));
  csa_device #(.CHANNELS(4)) u_csa_device (.clk(clk), .rst_b(rst_b), .link(link.device),
    .chanAwake(chanAwake), .startPulse(startPulse), .hopLoad(hopLoad));
  csa_properties u_csa_properties (.clk(clk), .rst_b(rst_b), .regReq(link.regReq), .regOp(link.regOp),
    .regAddr(link.regAddr), .regWdata(link.regWdata), .regRdata(link.regRdata), .regAck(link.regAck),
    .alignPin(link.alignPin));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic rdOp, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(negedge clk);
    while (cmdReady !== 1'b1 && k < 50)
    begin
      k++;
      @(negedge clk);
    end
    chk({7'h00, cmdReady}, 8'h01);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdRead <= rdOp;
    cmdAddr <= a;
    cmdData <= d;
    @(posedge clk);
    cmdValid <= 1'b0;
    @(negedge clk);
    tTaken = cyc;
    while (rdOp && rspValid !== 1'b1 && k < 60)
    begin
      k++;
      @(negedge clk);
    end
    if (rdOp)
    begin
      chk({7'h00, rspValid}, 8'h01);
    end
    rd = rspData;
    repeat (2) @(posedge clk);
  endtask
  task automatic waitEv(input logic isHop, input logic [3:0] exp);
    int k;
    k = 0;
    @(negedge clk);
    while ((isHop ? hopLoad : startPulse) === 4'h0 && k < 40)
    begin
      k++;
      @(negedge clk);
    end
    tEv = cyc;
    chk({4'h0, isHop ? hopLoad : startPulse}, {4'h0, exp});
  endtask
  task automatic quiet(input int n);
    logic [3:0] seen;
    seen = 4'h0;
    repeat (n)
    begin
      @(negedge clk);
      seen = seen | startPulse;
    end
    chk({4'h0, seen}, 8'h00);
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    rst_b = 1'b0;
    cmdValid = 1'b0;
    cmdRead = 1'b0;
    cmdAddr = 8'h00;
    cmdData = 8'h00;
    pinIn = 4'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk({4'h0, chanAwake}, 8'h00);
    acc(1'b1, `CSA_ADDR_PIN_CFG, 8'h00);
    chk(rd, 8'h00);
    acc(1'b1, 8'hff, 8'h00);
    chk(rd, 8'h00);
    acc(1'b0, `CSA_ADDR_CHAN_EN, 8'h03);
    acc(1'b0, `CSA_ADDR_START_LO, 8'h05);
    acc(1'b0, `CSA_ADDR_START_HI, 8'h00);
    acc(1'b0, `CSA_ADDR_SOFT_CFG, 8'h83);
    waitEv(1'b0, 4'h3);
    chk(8'(tEv - tTaken), 8'h06);
    chk({4'h0, chanAwake}, 8'h03);
    acc(1'b0, `CSA_ADDR_SLEEP, 8'h02);
    acc(1'b1, `CSA_ADDR_SLEEP, 8'h00);
    chk(rd, 8'h02);
    chk({4'h0, chanAwake}, 8'h02);
    acc(1'b1, `CSA_ADDR_STATUS, 8'h00);
    chk(rd, 8'h00);
    acc(1'b0, `CSA_ADDR_HOP_LO, 8'h03);
    acc(1'b0, `CSA_ADDR_HOP_HI, 8'h00);
    acc(1'b0, `CSA_ADDR_SOFT_CFG, 8'h00);
    acc(1'b0, `CSA_ADDR_SOFT_CFG, 8'h45);
    waitEv(1'b1, 4'h5);
    chk(8'(tEv - tTaken), 8'h04);
    acc(1'b0, `CSA_ADDR_PINSEL, 8'hf4);
    acc(1'b0, `CSA_ADDR_PIN_CFG, 8'ha2);
    acc(1'b1, `CSA_ADDR_PIN_CFG, 8'h00);
    chk(rd, 8'ha2);
    pinIn <= 4'h2;
    waitEv(1'b0, 4'h2);
    quiet(12);
    @(posedge clk);
    pinIn <= 4'h0;
    acc(1'b0, `CSA_ADDR_PIN_CFG, 8'h82);
    pinIn <= 4'h2;
    quiet(12);
    @(posedge clk);
    pinIn <= 4'h0;
    waitEv(1'b0, 4'h2);
    acc(1'b0, `CSA_ADDR_PIN_CFG, 8'h61);
    pinIn <= 4'h1;
    waitEv(1'b1, 4'h1);
    results();
  end
  initial
  begin
    #100us;
    n_errors++;
    results();
  end
endmodule
